/* File: hw/pms_pkg.sv */
// register map, field layout, reset values and divider constants of the pll sequencer
// assumes a 32-bit classic wishbone bus with byte addressing
package pms_pkg;

  localparam int          WB_AW          = 4;
  localparam int          WB_DW          = 32;
  localparam int          WB_SW          = 4;

  localparam logic [3:0]  ADDR_CTRL      = 4'h0;
  localparam logic [3:0]  ADDR_MULT      = 4'h4;
  localparam logic [3:0]  ADDR_STAT      = 4'h8;

  localparam int          CTRL_W         = 4;
  localparam int          CTRL_PON_BIT   = 0;
  localparam int          CTRL_TRK_BIT   = 1;
  localparam int          CTRL_BSEL_BIT  = 2;
  localparam int          CTRL_AUTO_BIT  = 3;
  localparam logic [3:0]  CTRL_RST       = 4'h0;

  localparam int          MULT_W         = 12;
  localparam int          MULT_LO_W      = 8;
  localparam logic [11:0] MULT_RST       = 12'h010;

  localparam int          STAT_LOCK_BIT  = 0;
  localparam int          STAT_AUTO_BIT  = 1;
  localparam int          STAT_UP_BIT    = 2;
  localparam int          STAT_DN_BIT    = 3;
  localparam int          STAT_TRK_BIT   = 4;
  localparam int          STAT_CNT_LSB   = 16;

  // vco runs at four times the bus clock
  localparam int          VCO_DIV_W      = 2;
  localparam logic [1:0]  VCO_DIV_LAST   = 2'h3;

  localparam logic [11:0] LOCK_TOL       = 12'h001;
  localparam logic [2:0]  LOCK_HITS      = 3'h3;

  typedef enum logic [0:0]
  {
    LK_UNLOCKED = 1'b0,
    LK_LOCKED   = 1'b1
  } pms_lock_e;

endpackage : pms_pkg

/* File: hw/pms_cmp_if.sv */
// carrier between the sequencer top and its phase comparator
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface pms_cmp_if #(
  parameter int CNT_W = 12
);
  logic             ref_tick;
  logic             vco_tick;
  logic             run;
  logic [CNT_W-1:0] mult;
  logic [CNT_W-1:0] count;
  logic             up;
  logic             dn;
  logic             done;

  modport cmp (input ref_tick, vco_tick, run, mult, output count, up, dn, done);
  modport ctl (output run, mult, input ref_tick, vco_tick, count, up, dn, done);
endinterface : pms_cmp_if

/* File: hw/pms_edge_det.sv */
// rising edge detector, registered one-cycle pulse
// assumes the input is already synchronous to clk_i
`timescale 1ns/100ps
module pms_edge_det (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic sig_i,
  output logic      rise_o
);
  logic prev_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prev_q <= 1'b0;
      rise_o <= 1'b0;
    end
    else if (ce_i)
    begin
      prev_q <= sig_i;
      rise_o <= sig_i & ~prev_q;
    end
  end
endmodule : pms_edge_det

/* File: hw/pms_phase_cmp.sv */
// counts vco edges over one reference period and compares with the multiplier
// assumes ticks are one-cycle pulses from the edge detectors
`timescale 1ns/100ps
module pms_phase_cmp #(
  parameter int CNT_W = 12
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  pms_cmp_if.cmp    cif
);
  logic [CNT_W-1:0] acc_q;
  logic [CNT_W-1:0] acc_inc;

  assign acc_inc = acc_q + {{(CNT_W-1){1'b0}}, 1'b1};

  // one correction per reference period, multiplier taken as integer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_q     <= '0;
      cif.count <= '0;
      cif.up    <= 1'b0;
      cif.dn    <= 1'b0;
      cif.done  <= 1'b0;
    end
    else if (ce_i)
    begin
      cif.done <= 1'b0;
      if (!cif.run)
      begin
        acc_q  <= '0;
        cif.up <= 1'b0;
        cif.dn <= 1'b0;
      end
      else if (cif.ref_tick)
      begin
        acc_q     <= cif.vco_tick ? {{(CNT_W-1){1'b0}}, 1'b1} : '0;
        cif.count <= acc_q;
        cif.up    <= acc_q < cif.mult;
        cif.dn    <= acc_q > cif.mult;
        cif.done  <= 1'b1;
      end
      else if (cif.vco_tick && (acc_inc != '0))
      begin
        acc_q <= acc_inc;
      end
    end
  end
endmodule : pms_phase_cmp

/* File: hw/pms_top.sv */
// manual-mode pll sequencer: control registers, phase comparison, clock select
// assumes a classic wishbone master and reference/vco levels synchronous to clk_i
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps

module pms_top
  import pms_pkg::*;
#(
  parameter int CNT_W = MULT_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [WB_SW-1:0] wb_sel_i,
  input  wire logic [WB_DW-1:0] wb_dat_i,
  output logic      [WB_DW-1:0] wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             ref_clk_i,
  input  wire logic             vco_clk_i,
  output logic                  pll_power_on_o,
  output logic                  filter_tracking_select_o,
  output logic                  pump_up_o,
  output logic                  pump_dn_o,
  output logic                  lock_o,
  output logic                  clk_gen_event_o,
  output logic                  clock_generator_output_o,
  output logic                  bus_clk_en_o
);

  logic [CTRL_W-1:0]    ctrl_q;
  logic [MULT_W-1:0]    mult_q;
  logic [WB_DW-1:0]     rdat_q;
  logic                 ack_q;
  logic [VCO_DIV_W-1:0] vdiv_q;
  logic [2:0]           hits_q;
  pms_lock_e            lock_q;
  pms_lock_e            lock_d;
  logic                 req;
  logic                 wr;
  logic                 pon;
  logic                 track_bit;
  logic                 bsel;
  logic                 auto_md;
  logic                 pll_src;
  logic [CNT_W-1:0]     err;
  logic                 in_tol;
  logic [WB_DW-1:0]     stat_word;

  pms_cmp_if #(.CNT_W(CNT_W)) cmp_if ();

  pms_edge_det u_ref_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .sig_i  (ref_clk_i),
    .rise_o (cmp_if.ref_tick)
  );

  pms_edge_det u_vco_edge (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .sig_i  (vco_clk_i),
    .rise_o (cmp_if.vco_tick)
  );

  pms_phase_cmp #(.CNT_W(CNT_W)) u_cmp (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .cif   (cmp_if.cmp)
  );

  assign pon       = ctrl_q[CTRL_PON_BIT];
  assign track_bit = ctrl_q[CTRL_TRK_BIT];
  assign bsel      = ctrl_q[CTRL_BSEL_BIT];
  assign auto_md   = ctrl_q[CTRL_AUTO_BIT];
  assign pll_src   = bsel & pon;

  assign cmp_if.run  = pon;
  assign cmp_if.mult = mult_q;

  // wishbone: request taken in its first cycle, ack one cycle later
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr  = req & wb_we_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_q <= req;
    end
  end

  // control bits are plain storage; power-on order is up to software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RST;
    end
    else if (ce_i && wr && (wb_adr_i == ADDR_CTRL) && wb_sel_i[0])
    begin
      ctrl_q <= wb_dat_i[CTRL_W-1:0];
    end
  end

  // multiplier must already be rounded to an integer by software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mult_q <= MULT_RST;
    end
    else if (ce_i && wr && (wb_adr_i == ADDR_MULT))
    begin
      if (wb_sel_i[0])
      begin
        mult_q[MULT_LO_W-1:0] <= wb_dat_i[MULT_LO_W-1:0];
      end
      if (wb_sel_i[1])
      begin
        mult_q[MULT_W-1:MULT_LO_W] <= wb_dat_i[MULT_W-1:MULT_LO_W];
      end
    end
  end

  always_comb
  begin
    stat_word                            = '0;
    stat_word[STAT_LOCK_BIT]             = lock_o;
    stat_word[STAT_AUTO_BIT]             = auto_md;
    stat_word[STAT_UP_BIT]               = cmp_if.up;
    stat_word[STAT_DN_BIT]               = cmp_if.dn;
    stat_word[STAT_TRK_BIT]              = filter_tracking_select_o;
    stat_word[STAT_CNT_LSB +: CNT_W]     = cmp_if.count;
  end

  // unmapped addresses are acked and read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdat_q <= '0;
    end
    else if (ce_i && req)
    begin
      case (wb_adr_i)
        ADDR_CTRL: rdat_q <= {{(WB_DW-CTRL_W){1'b0}}, ctrl_q};
        ADDR_MULT: rdat_q <= {{(WB_DW-MULT_W){1'b0}}, mult_q};
        ADDR_STAT: rdat_q <= stat_word;
        default:   rdat_q <= '0;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  assign err    = (cmp_if.count >= mult_q) ? (cmp_if.count - mult_q) : (mult_q - cmp_if.count);
  assign in_tol = err <= LOCK_TOL;

  // lock detection runs only in automatic mode
  always_comb
  begin
    lock_d = lock_q;
    case (lock_q)
      LK_UNLOCKED:
      begin
        if (cmp_if.done && in_tol && (hits_q == LOCK_HITS))
        begin
          lock_d = LK_LOCKED;
        end
      end
      LK_LOCKED:
      begin
        if (cmp_if.done && !in_tol)
        begin
          lock_d = LK_UNLOCKED;
        end
      end
      default:
      begin
        lock_d = LK_UNLOCKED;
      end
    endcase
    if (!auto_md || !pon)
    begin
      lock_d = LK_UNLOCKED;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_q <= LK_UNLOCKED;
      hits_q <= '0;
    end
    else if (ce_i)
    begin
      lock_q <= lock_d;
      if (!auto_md || !pon || (cmp_if.done && !in_tol))
      begin
        hits_q <= '0;
      end
      else if (cmp_if.done && (hits_q != LOCK_HITS))
      begin
        hits_q <= hits_q + 3'h1;
      end
    end
  end

  // lock and event outputs are gated so manual mode never shows either
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_o          <= 1'b0;
      clk_gen_event_o <= 1'b0;
    end
    else if (ce_i)
    begin
      lock_o          <= auto_md & (lock_d == LK_LOCKED);
      clk_gen_event_o <= auto_md & (lock_d != lock_q);
    end
  end

  // filter mode and charge pump
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pll_power_on_o           <= 1'b0;
      filter_tracking_select_o <= 1'b0;
      pump_up_o                <= 1'b0;
      pump_dn_o                <= 1'b0;
    end
    else if (ce_i)
    begin
      pll_power_on_o           <= pon;
      filter_tracking_select_o <= auto_md ? (lock_d == LK_LOCKED) : track_bit;
      pump_up_o                <= pon & cmp_if.done & cmp_if.up;
      pump_dn_o                <= pon & cmp_if.done & cmp_if.dn;
    end
  end

  // vco divided by four gives the bus clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vdiv_q <= '0;
    end
    else if (ce_i)
    begin
      if (!pon)
      begin
        vdiv_q <= '0;
      end
      else if (cmp_if.vco_tick)
      begin
        vdiv_q <= vdiv_q + 2'h1;
      end
    end
  end

  // clock select is not glitch free: output follows the new source at once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clock_generator_output_o <= 1'b0;
      bus_clk_en_o             <= 1'b0;
    end
    else if (ce_i)
    begin
      clock_generator_output_o <= pll_src ? vdiv_q[VCO_DIV_W-1] : ref_clk_i;
      bus_clk_en_o             <= pll_src ? (cmp_if.vco_tick & (vdiv_q == VCO_DIV_LAST))
                                          : cmp_if.ref_tick;
    end
  end

endmodule : pms_top

/* File: dv/pms_osc_model.sv */
// crystal reference and vco stand-ins, both free-running levels
// assumes clk_i is the bench clock; half periods are counted in its cycles
`timescale 1ns/100ps
module pms_osc_model #(
  parameter int REF_HALF = 20,
  parameter int VCO_HALF = 2
) (
  input  wire logic clk_i,
  output logic      ref_clk_o,
  output logic      vco_clk_o
);
  int rc = 0;
  int vc = 0;
  logic ref_q = 1'b0;
  logic vco_q = 1'b0;
  assign ref_clk_o = ref_q;
  assign vco_clk_o = vco_q;
  // both stay far below clk/2 so the synchronous sampling never misses an edge
  always @(posedge clk_i)
  begin
    rc <= (rc == REF_HALF - 1) ? 0 : rc + 1;
    vc <= (vc == VCO_HALF - 1) ? 0 : vc + 1;
    if (rc == REF_HALF - 1) ref_q <= ~ref_q;
    if (vc == VCO_HALF - 1) vco_q <= ~vco_q;
  end
endmodule : pms_osc_model

/* File: dv/pms_top_sva.sv */
// port assertions for the manual-mode pll sequencer
// assumes one clock and sync reset; checks pause while the clock enable is low
`timescale 1ns/100ps
module pms_top_sva
  import pms_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [WB_SW-1:0] wb_sel_i,
  input wire logic [WB_DW-1:0] wb_dat_i,
  input wire logic             wb_ack_o,
  input wire logic             ref_clk_i,
  input wire logic             pll_power_on_o,
  input wire logic             filter_tracking_select_o,
  input wire logic             pump_up_o,
  input wire logic             pump_dn_o,
  input wire logic             lock_o,
  input wire logic             clk_gen_event_o,
  input wire logic             clock_generator_output_o
);
  logic       req;
  logic       wr_c;
  logic       auto_q;
  logic       pll_q;
  logic       ref_q;
  logic [3:0] since_q;
  default clocking @(posedge clk_i); endclocking
  // a frozen block holds pulses high, so nothing is judged while ce_i is low
  default disable iff (rst_i || !ce_i);
  assign req  = ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_c = req && wb_we_i && wb_adr_i == ADDR_CTRL && wb_sel_i[0];
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      auto_q <= 1'b0;
      pll_q  <= 1'b0;
    end
    else if (wr_c)
    begin
      auto_q <= wb_dat_i[CTRL_AUTO_BIT];
      pll_q  <= wb_dat_i[CTRL_BSEL_BIT] & wb_dat_i[CTRL_PON_BIT];
    end
  end
  // saturates so a slow reference cannot wrap it into the pump window
  always_ff @(posedge clk_i)
  begin
    ref_q   <= ref_clk_i;
    since_q <= (ref_clk_i && !ref_q) ? 4'h0 : (since_q == 4'hf) ? 4'hf : since_q + 4'h1;
  end
  ack_timing_a: assert property (req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  filter_mode_a: assert property (wr_c && !wb_dat_i[CTRL_AUTO_BIT]
    |-> ##2 filter_tracking_select_o == $past(wb_dat_i[CTRL_TRK_BIT], 2))
    else $error("filter mode does not follow tracking bit");
  power_copy_a: assert property (wr_c
    |-> ##2 pll_power_on_o == $past(wb_dat_i[CTRL_PON_BIT], 2))
    else $error("power output does not follow control write");
  lock_off_a: assert property (!auto_q && !$past(auto_q) |-> !lock_o)
    else $error("lock shown in manual mode");
  event_off_a: assert property (!auto_q && !$past(auto_q) |-> !clk_gen_event_o)
    else $error("event raised in manual mode");
  pump_window_a: assert property (pump_up_o || pump_dn_o |-> since_q <= 4'h6)
    else $error("pump pulse away from reference edge");
  pump_pulse_a: assert property (pump_up_o || pump_dn_o |=> !pump_up_o && !pump_dn_o)
    else $error("pump pulse longer than one cycle");
  ref_route_a: assert property (!$past(rst_i) && !pll_q && !$past(pll_q) && !$past(pll_q, 2)
    |-> clock_generator_output_o == $past(ref_clk_i))
    else $error("output clock not the reference");
endmodule : pms_top_sva

bind pms_top pms_top_sva u_sva (
  .clk_i                    (clk_i),
  .rst_i                    (rst_i),
  .ce_i                     (ce_i),
  .wb_cyc_i                 (wb_cyc_i),
  .wb_stb_i                 (wb_stb_i),
  .wb_we_i                  (wb_we_i),
  .wb_adr_i                 (wb_adr_i),
  .wb_sel_i                 (wb_sel_i),
  .wb_dat_i                 (wb_dat_i),
  .wb_ack_o                 (wb_ack_o),
  .ref_clk_i                (ref_clk_i),
  .pll_power_on_o           (pll_power_on_o),
  .filter_tracking_select_o (filter_tracking_select_o),
  .pump_up_o                (pump_up_o),
  .pump_dn_o                (pump_dn_o),
  .lock_o                   (lock_o),
  .clk_gen_event_o          (clk_gen_event_o),
  .clock_generator_output_o (clock_generator_output_o)
);

/* File: dv/pms_top_tb_top.sv */
// self-checking bench for the manual-mode pll sequencer
// assumes pms_osc_model supplies reference and vco levels
`timescale 1ns/100ps
module pms_top_tb_top
  import pms_pkg::*;
;
  localparam int VH = 2;
  localparam int RH = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic        ack, refc, vco, pon, trk, up, dn, lock, evt, cgo, en, prv;
  int          miscompares = 0;
  int          comparisons = 0;
  int          n, p, e, r, v;
  // multiplier beside {up pulses, down pulses} over two reference periods
  logic [11:0] rm [3] = '{12'h00a, 12'h00c, 12'h008};
  logic [3:0]  rp [3] = '{4'h0, 4'h8, 4'h2};
  always #4 clk_i = ~clk_i;
  pms_osc_model #(.REF_HALF(RH), .VCO_HALF(VH)) osc (.clk_i(clk_i), .ref_clk_o(refc),
    .vco_clk_o(vco));
  pms_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .ref_clk_i(refc), .vco_clk_i(vco), .pll_power_on_o(pon),
    .filter_tracking_select_o(trk), .pump_up_o(up), .pump_dn_o(dn), .lock_o(lock),
    .clk_gen_event_o(evt), .clock_generator_output_o(cgo), .bus_clk_en_o(en));
  task automatic tally_and_finish;
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x)
    begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = dat_o;
    chk(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] x);
    bus(1'b0, a, 4'hf, 32'h0);
    chk(q & m, x);
  endtask : rd
  // samples pumps, bus enables and output clock rises over c cycles
  task automatic cnt(input int c);
    n = 0;
    p = 0;
    e = 0;
    r = 0;
    v = 0;
    prv = cgo;
    repeat (c)
    begin
      @(posedge clk_i);
      n += up;
      p += dn;
      e += en;
      r += (cgo && !prv);
      v += evt;
      prv = cgo;
    end
  endtask : cnt
  initial
  begin
    repeat (6) @(posedge clk_i);
    chk({pon, trk, up, dn, lock, evt, cgo, en}, 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_CTRL, 32'hf, 32'h0);
    rd(ADDR_MULT, 32'hfff, 32'(MULT_RST));
    rd(ADDR_STAT, 32'hffff_ffff, 32'h0);
    bus(1'b1, 4'hc, 4'hf, 32'hffff_ffff);
    rd(4'hc, 32'hffff_ffff, 32'h0);
    rd(ADDR_CTRL, 32'hffff_ffff, 32'h0);
    bus(1'b1, ADDR_MULT, 4'h2, 32'h0000_0aff);
    rd(ADDR_MULT, 32'hfff, 32'h0000_0a10);
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, ADDR_CTRL, 4'hf, 32'(i));
      @(posedge clk_i);
      chk({pon, trk}, {i[0], i[1]});
      rd(ADDR_STAT, 32'h13, {27'h0, i[1], 4'h0});
    end
    bus(1'b1, ADDR_MULT, 4'hf, 32'(rm[0]));
    bus(1'b1, ADDR_CTRL, 4'hf, 32'h0);
    bus(1'b1, ADDR_CTRL, 4'hf, 32'h1);
    repeat (4 * RH) @(posedge clk_i);
    bus(1'b1, ADDR_CTRL, 4'hf, 32'h3);
    repeat (4 * RH) @(posedge clk_i);
    bus(1'b1, ADDR_CTRL, 4'hf, 32'h7);
    repeat (16) @(posedge clk_i);
    cnt(32 * VH);
    chk(r, 4);
    chk(e, 4);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, ADDR_MULT, 4'hf, 32'(rm[i]));
      repeat (6 * RH) @(posedge clk_i);
      cnt(4 * RH);
      chk(n * 4 + p, 32'(rp[i]));
    end
    rd(ADDR_STAT, 32'h0fff_0001, 32'(RH / VH) << 16);
    // automatic mode: four in-tolerance periods give lock and a single event
    bus(1'b1, ADDR_MULT, 4'hf, 32'(rm[0]));
    bus(1'b1, ADDR_CTRL, 4'hf, 32'h9);
    cnt(10 * RH);
    chk(v, 1);
    chk({lock, trk}, 2'b11);
    rd(ADDR_STAT, 32'h13, 32'h13);
    bus(1'b1, ADDR_CTRL, 4'hf, 32'h1);
    cnt(2 * RH);
    chk(v, 0);
    chk({lock, trk}, 2'b00);
    rd(ADDR_STAT, 32'h13, 32'h0);
    // clock enable low must freeze the output clock and the control state
    ce <= 1'b0;
    cnt(4 * RH);
    chk(r, 0);
    chk(pon, 1'b1);
    rst_i <= 1'b1;
    ce    <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({pon, trk, up, dn, lock, evt, cgo, en}, 32'h0);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_CTRL, 32'hf, 32'h0);
    tally_and_finish();
  end
  initial
  begin
    repeat (5000) @(posedge clk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule : pms_top_tb_top
